// [pim_pkg.sv]
// Purpose: Shared constants for the PHY interrupt enable and mask block
// Assumes: Registers reached over AXI4-Lite, one 32-bit word per register
// Notes:   Printed offsets are register indexes; byte address is index x 4
`default_nettype none

package pim_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam int unsigned ADDR_W      = 8;
  localparam int unsigned REG_W       = 16;
  localparam logic [7:0]  MASK_IDX    = 8'h18;
  localparam logic [7:0]  STATUS_IDX  = 8'h19;
  localparam logic [7:0]  MASK_ADDR   = {MASK_IDX[5:0], 2'h0};
  localparam logic [7:0]  STATUS_ADDR = {STATUS_IDX[5:0], 2'h0};

  // ----------------------------------------------------------------
  // Field positions, shared by enable and status words
  // ----------------------------------------------------------------
  localparam int unsigned BIT_PIN_EN  = 0;
  localparam int unsigned BIT_PENDING = 0;
  localparam int unsigned BIT_SPEED   = 1;
  localparam int unsigned BIT_LINK    = 2;
  localparam int unsigned BIT_RX      = 3;
  localparam int unsigned BIT_FIFO    = 4;
  localparam int unsigned BIT_IDLE    = 5;
  localparam int unsigned BIT_PAGE    = 6;
  localparam int unsigned BIT_FCFG    = 7;
  localparam int unsigned BIT_NEG     = 8;
  localparam int unsigned BIT_SYNC    = 9;
  localparam int unsigned BIT_CABLE   = 10;
  localparam int unsigned NUM_EVT     = 10;
  localparam int unsigned FIELD_W     = NUM_EVT + 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [10:0] MASK_RST    = 11'h000;
  localparam logic        STICKY_RST  = 1'h0;
  localparam logic        ALERT_N_RST = 1'h1;

  // ----------------------------------------------------------------
  // Bus responses and channel states
  // ----------------------------------------------------------------
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    WR_COLLECT = 2'h1,
    WR_RESP    = 2'h2
  } pim_wr_state_t;

  typedef enum logic [1:0] {
    RD_IDLE = 2'h1,
    RD_DATA = 2'h2
  } pim_rd_state_t;

endpackage

`default_nettype wire

// [pim_sticky_bit.sv]
// Purpose: One latched event flag with set priority over clear
// Assumes: Set and clear are single-clock signals on aclk
// Notes:   A set in the clearing cycle leaves the flag high
`timescale 1ns/1ps
`default_nettype none

module pim_sticky_bit #(
  parameter logic RST_VAL = pim_pkg::STICKY_RST
) (
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic set,
  input  wire logic clear,
  // Flag
  output logic      flag
);

  logic flag_ff;

  // ----------------------------------------------------------------
  // Flag storage
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_ff <= RST_VAL;
    end else if (set) begin
      flag_ff <= 1'h1;
    end else if (clear) begin
      flag_ff <= 1'h0;
    end
  end

  assign flag = flag_ff;

endmodule

`default_nettype wire

// [pim_irq_enable.sv]
// Purpose: Interrupt enable, status latch and alert pin of a PHY
// Assumes: Event inputs are one-cycle pulses on aclk
// Notes:   Status reads clear every latched bit at once unless its event fires in the read cycle
//
// The address map and register access over AXI4-Lite are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none

module pim_irq_enable (
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  // AXI4-Lite write data
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read address
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // Event sources
  input  wire logic        cable_diag_evt,
  input  wire logic        sync_lost_evt,
  input  wire logic        negotiation_change_evt,
  input  wire logic        frame_checker_evt,
  input  wire logic        page_received_evt,
  input  wire logic        idle_error_saturate_evt,
  input  wire logic        mac_fifo_flow_evt,
  input  wire logic        receive_change_evt,
  input  wire logic        link_change_evt,
  input  wire logic        speed_change_evt,
  // Interrupt pin
  output logic             alert_n
);

  localparam int unsigned NE = pim_pkg::NUM_EVT;

  pim_pkg::pim_wr_state_t wr_state_ff;
  pim_pkg::pim_rd_state_t rd_state_ff;

  logic [10:0] mask_ff;
  logic        aw_held_ff;
  logic [7:0]  awaddr_ff;
  logic        w_held_ff;
  logic [31:0] wdata_ff;
  logic [3:0]  wstrb_ff;
  logic [1:0]  bresp_ff;
  logic [31:0] rdata_ff;
  logic [1:0]  rresp_ff;
  logic        alert_n_ff;
  logic [NE-1:0] evt_vec;
  logic [NE-1:0] stat_q;
  logic [NE-1:0] src_enable;
  logic        pending_q;
  logic        pending_set;
  logic        aw_take;
  logic        w_take;
  logic        do_write;
  logic        ar_take;
  logic        status_rd;
  logic [15:0] status_word;

  // ----------------------------------------------------------------
  // Event vector in status bit order
  // ----------------------------------------------------------------
  assign evt_vec = {cable_diag_evt, sync_lost_evt, negotiation_change_evt,
                    frame_checker_evt, page_received_evt,
                    idle_error_saturate_evt, mac_fifo_flow_evt,
                    receive_change_evt, link_change_evt, speed_change_evt};

  // Source enables sit directly above the pin enable
  assign src_enable = mask_ff[pim_pkg::BIT_CABLE:pim_pkg::BIT_SPEED];

  // ----------------------------------------------------------------
  // Status latches
  // ----------------------------------------------------------------
  assign status_rd = ar_take && (s_axi_araddr == pim_pkg::STATUS_ADDR);

  genvar gi;
  generate
    for (gi = 0; gi < NE; gi++) begin : g_stat
      pim_sticky_bit #(
        .RST_VAL (pim_pkg::STICKY_RST)
      ) u_stat (
        .aclk    (aclk),
        .aresetn (aresetn),
        .set     (evt_vec[gi]),
        .clear   (status_rd),
        .flag    (stat_q[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Pending flag
  // ----------------------------------------------------------------
  assign pending_set = |(evt_vec & src_enable);

  pim_sticky_bit #(
    .RST_VAL (pim_pkg::STICKY_RST)
  ) u_pending (
    .aclk    (aclk),
    .aresetn (aresetn),
    .set     (pending_set),
    .clear   (status_rd),
    .flag    (pending_q)
  );

  assign status_word = {5'h00, stat_q, pending_q};

  // ----------------------------------------------------------------
  // Alert pin
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alert_n_ff <= pim_pkg::ALERT_N_RST;
    end else begin
      alert_n_ff <= !(pending_q && mask_ff[pim_pkg::BIT_PIN_EN]);
    end
  end

  assign alert_n = alert_n_ff;

  // ----------------------------------------------------------------
  // Write channel
  // ----------------------------------------------------------------
  assign s_axi_awready = (wr_state_ff == pim_pkg::WR_COLLECT) && !aw_held_ff;
  assign s_axi_wready  = (wr_state_ff == pim_pkg::WR_COLLECT) && !w_held_ff;
  assign aw_take       = s_axi_awvalid && s_axi_awready;
  assign w_take        = s_axi_wvalid && s_axi_wready;
  assign do_write      = (wr_state_ff == pim_pkg::WR_COLLECT) &&
                         aw_held_ff && w_held_ff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'h0;
      awaddr_ff  <= 8'h00;
    end else if (aw_take) begin
      aw_held_ff <= 1'h1;
      awaddr_ff  <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held_ff <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_ff <= 1'h0;
      wdata_ff  <= 32'h0000_0000;
      wstrb_ff  <= 4'h0;
    end else if (w_take) begin
      w_held_ff <= 1'h1;
      wdata_ff  <= s_axi_wdata;
      wstrb_ff  <= s_axi_wstrb;
    end else if (do_write) begin
      w_held_ff <= 1'h0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wr_state_ff <= pim_pkg::WR_COLLECT;
      bresp_ff    <= pim_pkg::RESP_OKAY;
    end else begin
      case (wr_state_ff)
        pim_pkg::WR_COLLECT: begin
          if (do_write) begin
            wr_state_ff <= pim_pkg::WR_RESP;
            if ((awaddr_ff == pim_pkg::MASK_ADDR) ||
                (awaddr_ff == pim_pkg::STATUS_ADDR)) begin
              bresp_ff <= pim_pkg::RESP_OKAY;
            end else begin
              bresp_ff <= pim_pkg::RESP_SLVERR;
            end
          end
        end
        pim_pkg::WR_RESP: begin
          if (s_axi_bready) begin
            wr_state_ff <= pim_pkg::WR_COLLECT;
          end
        end
        default: begin
          wr_state_ff <= pim_pkg::WR_COLLECT;
        end
      endcase
    end
  end

  assign s_axi_bvalid = (wr_state_ff == pim_pkg::WR_RESP);
  assign s_axi_bresp  = bresp_ff;

  // ----------------------------------------------------------------
  // Enable register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_ff <= pim_pkg::MASK_RST;
    end else if (do_write && (awaddr_ff == pim_pkg::MASK_ADDR)) begin
      if (wstrb_ff[0]) begin
        mask_ff[7:0] <= wdata_ff[7:0];
      end
      if (wstrb_ff[1]) begin
        mask_ff[10:8] <= wdata_ff[10:8];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  assign s_axi_arready = (rd_state_ff == pim_pkg::RD_IDLE);
  assign ar_take       = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state_ff <= pim_pkg::RD_IDLE;
      rdata_ff    <= 32'h0000_0000;
      rresp_ff    <= pim_pkg::RESP_OKAY;
    end else begin
      case (rd_state_ff)
        pim_pkg::RD_IDLE: begin
          if (ar_take) begin
            rd_state_ff <= pim_pkg::RD_DATA;
            if (s_axi_araddr == pim_pkg::MASK_ADDR) begin
              rdata_ff <= {21'h0, mask_ff};
              rresp_ff <= pim_pkg::RESP_OKAY;
            end else if (status_rd) begin
              rdata_ff <= {16'h0000, status_word};
              rresp_ff <= pim_pkg::RESP_OKAY;
            end else begin
              rdata_ff <= 32'h0000_0000;
              rresp_ff <= pim_pkg::RESP_SLVERR;
            end
          end
        end
        pim_pkg::RD_DATA: begin
          if (s_axi_rready) begin
            rd_state_ff <= pim_pkg::RD_IDLE;
          end
        end
        default: begin
          rd_state_ff <= pim_pkg::RD_IDLE;
        end
      endcase
    end
  end

  assign s_axi_rvalid = (rd_state_ff == pim_pkg::RD_DATA);
  assign s_axi_rdata  = rdata_ff;
  assign s_axi_rresp  = rresp_ff;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking

  default disable iff (!aresetn);

  pin_off_a: assert property (
    !mask_ff[pim_pkg::BIT_PIN_EN] |=> alert_n)
    else $error("Alert pin active while pin enable is clear");

  pin_on_a: assert property (
    (pending_q && mask_ff[pim_pkg::BIT_PIN_EN]) |=> !alert_n)
    else $error("Alert pin idle with enabled pending interrupt");

  src_gate_a: assert property (
    (!pending_q && !status_rd && ((evt_vec & src_enable) == '0))
      |=> !pending_q)
    else $error("Pending set by a masked or absent event");

  pend_set_a: assert property (
    ((evt_vec & src_enable) != '0) |=> pending_q)
    else $error("Enabled event did not set pending");

  stat_set_a: assert property (
    (evt_vec != '0) |=> ((stat_q & $past(evt_vec)) == $past(evt_vec)))
    else $error("Event did not latch its status bit");

  stat_hold_a: assert property (
    !status_rd |=> ((stat_q & $past(stat_q)) == $past(stat_q)))
    else $error("Status bit dropped without a status read");

  read_clear_a: assert property (
    (status_rd && (evt_vec == '0)) |=> ((stat_q == '0) && !pending_q))
    else $error("Status read did not clear latched bits");

  pin_release_a: assert property (
    (status_rd && (evt_vec == '0)) |-> ##2 alert_n)
    else $error("Alert pin held after pending was cleared");

  reset_en_a: assert property (
    disable iff (1'b0) !aresetn |=> ((mask_ff == '0) && alert_n))
    else $error("Enables or alert pin wrong after reset");

  bus_hold_a: assert property (
    (s_axi_rvalid && !s_axi_rready) |=> (s_axi_rvalid && $stable(s_axi_rdata)))
    else $error("Read data changed before it was taken");

  evt_to_pin_c: cover property (
    pending_set ##1 pending_q [*2] ##0 !alert_n);

  read_clear_c: cover property (
    (pending_q && status_rd) ##1 !pending_q);

  masked_evt_c: cover property (
    ((evt_vec & ~src_enable) != '0) ##1 (stat_q != '0) && !pending_q);

endmodule

`default_nettype wire

// [pim_evt_model.sv]
// Purpose: Event source model standing in for the PHY event logic
// Assumes: The bench raises fire for one cycle per wanted event pulse
// Notes:   Each event follows its request one edge later
`timescale 1ns/1ps
`default_nettype none

module pim_evt_model (
  // Clock
  input  wire logic        aclk,
  // Requests, bit n feeds status bit n
  input  wire logic [10:1] fire,
  // Event outputs
  output logic             cable_diag_evt,
  output logic             sync_lost_evt,
  output logic             negotiation_change_evt,
  output logic             frame_checker_evt,
  output logic             page_received_evt,
  output logic             idle_error_saturate_evt,
  output logic             mac_fifo_flow_evt,
  output logic             receive_change_evt,
  output logic             link_change_evt,
  output logic             speed_change_evt
);
  logic [10:1] evt_ff = 10'h000;

  // Launches one pulse per request cycle
  always @(posedge aclk) begin
    evt_ff <= fire;
  end

  assign cable_diag_evt          = evt_ff[10];
  assign sync_lost_evt           = evt_ff[9];
  assign negotiation_change_evt  = evt_ff[8];
  assign frame_checker_evt       = evt_ff[7];
  assign page_received_evt       = evt_ff[6];
  assign idle_error_saturate_evt = evt_ff[5];
  assign mac_fifo_flow_evt       = evt_ff[4];
  assign receive_change_evt      = evt_ff[3];
  assign link_change_evt         = evt_ff[2];
  assign speed_change_evt        = evt_ff[1];
endmodule

`default_nettype wire

// [pim_tb.sv]
// Purpose: Self-checking bench for the interrupt enable block
// Assumes: AXI4-Lite master tasks, event model on the far side
// Notes:   Status reads clear all latched bits except those whose event fires in the read cycle
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [7:0]  awaddr = 8'h00;
  logic        awvalid = 1'b0;
  logic        awready;
  logic [31:0] wdata = 32'h0;
  logic        wvalid = 1'b0;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready = 1'b0;
  logic [7:0]  araddr = 8'h00;
  logic        arvalid = 1'b0;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready = 1'b0;
  logic [10:1] fire = 10'h000;
  wire logic [10:1] ev;
  logic        alert_n;
  int          err_total = 0;
  int          checks = 0;
  int          cyc_cnt = 0;
  logic [31:0] d;
  logic [1:0]  r;

  pim_evt_model part (.aclk(aclk), .fire(fire),
    .cable_diag_evt(ev[10]), .sync_lost_evt(ev[9]),
    .negotiation_change_evt(ev[8]), .frame_checker_evt(ev[7]),
    .page_received_evt(ev[6]), .idle_error_saturate_evt(ev[5]),
    .mac_fifo_flow_evt(ev[4]), .receive_change_evt(ev[3]),
    .link_change_evt(ev[2]), .speed_change_evt(ev[1]));

  pim_irq_enable dut (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cable_diag_evt(ev[10]), .sync_lost_evt(ev[9]),
    .negotiation_change_evt(ev[8]), .frame_checker_evt(ev[7]),
    .page_received_evt(ev[6]), .idle_error_saturate_evt(ev[5]),
    .mac_fifo_flow_evt(ev[4]), .receive_change_evt(ev[3]),
    .link_change_evt(ev[2]), .speed_change_evt(ev[1]),
    .alert_n(alert_n));

  initial begin
    forever #12.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Helper tasks
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("Checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
    #1;
  endtask

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v,
                           output logic [1:0] rs);
    logic ta, tw, tb;
    @(posedge aclk);
    awaddr  <= a;
    wdata   <= v;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    tb = 1'b0;
    while (!tb) begin
      #1;
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      rs = bresp;
      @(posedge aclk);
      if (ta) awvalid <= 1'b0;
      if (tw) wvalid <= 1'b0;
      if (tb) bready <= 1'b0;
    end
  endtask

  task automatic axi_read(input logic [7:0] a, output logic [31:0] v,
                          output logic [1:0] rs);
    logic ta, tr;
    @(posedge aclk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    tr = 1'b0;
    while (!tr) begin
      #1;
      ta = arvalid && arready;
      tr = rvalid && rready;
      v  = rdata;
      rs = rresp;
      @(posedge aclk);
      if (ta) arvalid <= 1'b0;
      if (tr) rready <= 1'b0;
    end
  endtask

  task automatic fire_evt(input logic [10:1] v);
    @(posedge aclk);
    fire <= v;
    @(posedge aclk);
    fire <= 10'h000;
  endtask

  // ----------------------------------------------------------------
  // Timeout
  // ----------------------------------------------------------------
  always @(posedge aclk) begin
    cyc_cnt++;
    if (cyc_cnt == 20000) begin
      err_total++;
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    cyc(1);
    chk("alert_n reset", {31'h0, alert_n}, 32'h1);
    axi_read(pim_pkg::MASK_ADDR, d, r);
    chk("enable reset", d, 32'h0);
    axi_read(pim_pkg::STATUS_ADDR, d, r);
    chk("status reset", d, 32'h0);
    $display("Test reset done");

    fire_evt(10'h3ff);
    cyc(3);
    chk("alert_n masked", {31'h0, alert_n}, 32'h1);
    axi_read(pim_pkg::STATUS_ADDR, d, r);
    chk("status latched", d, 32'h7fe);
    axi_read(pim_pkg::STATUS_ADDR, d, r);
    chk("status cleared", d, 32'h0);
    $display("Test latch done");

    for (int i = 1; i <= 10; i++) begin
      axi_write(pim_pkg::MASK_ADDR, 32'h1 | (32'h1 << i), r);
      fire_evt(10'h3ff & ~(10'h1 << (i - 1)));
      cyc(3);
      chk("alert_n other", {31'h0, alert_n}, 32'h1);
      fire_evt(10'h1 << (i - 1));
      cyc(3);
      chk("alert_n own", {31'h0, alert_n}, 32'h0);
      axi_read(pim_pkg::STATUS_ADDR, d, r);
      chk("status source", d, 32'h7ff);
      cyc(2);
      chk("alert_n release", {31'h0, alert_n}, 32'h1);
    end
    $display("Test sources done");

    axi_write(pim_pkg::MASK_ADDR, 32'h7fe, r);
    fire_evt(10'h200);
    cyc(4);
    chk("alert_n pin off", {31'h0, alert_n}, 32'h1);
    axi_write(pim_pkg::MASK_ADDR, 32'h7ff, r);
    cyc(1);
    chk("alert_n pin on", {31'h0, alert_n}, 32'h0);
    axi_read(pim_pkg::STATUS_ADDR, d, r);
    chk("status pending", d, 32'h401);
    cyc(2);
    chk("alert_n cleared", {31'h0, alert_n}, 32'h1);
    $display("Test pin done");

    // Event landing in the clearing cycle stays latched
    fork
      fire_evt(10'h001);
      begin
        @(posedge aclk);
        axi_read(pim_pkg::STATUS_ADDR, d, r);
      end
    join
    chk("status collide", d, 32'h0);
    axi_read(pim_pkg::STATUS_ADDR, d, r);
    chk("status set wins", d, 32'h3);
    $display("Test collide done");

    axi_write(pim_pkg::MASK_ADDR, 32'hffffffff, r);
    chk("enable wr resp", {30'h0, r}, {30'h0, pim_pkg::RESP_OKAY});
    axi_read(pim_pkg::MASK_ADDR, d, r);
    chk("enable readback", d, 32'h7ff);
    chk("enable rd resp", {30'h0, r}, {30'h0, pim_pkg::RESP_OKAY});
    axi_write(pim_pkg::STATUS_ADDR, 32'hffffffff, r);
    chk("status wr resp", {30'h0, r}, {30'h0, pim_pkg::RESP_OKAY});
    axi_read(pim_pkg::STATUS_ADDR, d, r);
    chk("status ro", d, 32'h0);
    axi_read(8'h00, d, r);
    chk("unmapped rd resp", {30'h0, r}, {30'h0, pim_pkg::RESP_SLVERR});
    chk("unmapped rd data", d, 32'h0);
    axi_write(8'h00, 32'h1, r);
    chk("unmapped wr resp", {30'h0, r}, {30'h0, pim_pkg::RESP_SLVERR});
    $display("Test bus done");
    end_sim();
  end
endmodule

`default_nettype wire
